// File: logic/adc_out_core.sv
// Purpose: output coding, pipelines, data ready and sync of two channels
// Assumes: samp_clk and sync pin are asynchronous to clk_sys
// Notes: mode inputs are static straps on the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module adc_out_core
   import adc_out_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // sampling clock and sync pins
   input wire logic samp_clk,
   input wire logic sync_trigger_input,
   output logic chained_sync_output,
   // mode straps
   input wire logic sync_edge_select,
   input wire logic two_word_mode,
   input wire logic interleave,
   // raw sample stream
   input wire logic sample_valid,
   input wire raw_pair_t sample,
   output logic sample_ready,
   // output ports
   output port_out_t [NCH-1:0] channel_port,
   output logic [NCH-1:0] channel_data_ready
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   // pin synchronisers
   logic samp_s1_ff, samp_s2_ff, samp_s3_ff;
   logic sync_s1_ff, sync_s2_ff;
   logic rise, fall, cap_en;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         samp_s1_ff <= 1'b0;
         samp_s2_ff <= 1'b0;
         samp_s3_ff <= 1'b0;
         sync_s1_ff <= 1'b0;
         sync_s2_ff <= 1'b0;
      end else begin
         samp_s1_ff <= samp_clk;
         samp_s2_ff <= samp_s1_ff;
         samp_s3_ff <= samp_s2_ff;
         sync_s1_ff <= sync_trigger_input;
         sync_s2_ff <= sync_s1_ff;
      end
   end

   always_comb begin
      rise = samp_s2_ff && !samp_s3_ff;
      fall = !samp_s2_ff && samp_s3_ff;
      cap_en = sync_edge_select ? fall : rise; // R07
   end

   // sample buffer
   logic fifo_vld;
   raw_pair_t fifo_dat;
   coded_t enc [NCH];
   coded_t tap_hi [NCH];
   coded_t tap_lo [NCH];

   sample_fifo #(
      .WIDTH($bits(raw_pair_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .in_valid(sample_valid),
      .in_data(sample),
      .in_ready(sample_ready),
      .out_valid(fifo_vld),
      .out_data(fifo_dat),
      .out_ready(rise)
   );

   // coding and pipelines; an empty buffer feeds midscale
   always_comb begin
      enc[0] = encode(fifo_vld ? fifo_dat.a : '0);
      enc[1] = encode(fifo_vld ? fifo_dat.b : '0);
   end

   for (genvar ch = 0; ch < NCH; ch++) begin : g_pipe
      pipe_delay #(
         .DEPTH(PIPE_HI_LAT),
         .HI_TAP(PIPE_HI_LAT),
         .LO_TAP(PIPE_LO_LAT)
      ) u_pipe (
         .clk_sys(clk_sys),
         .nrst(nrst),
         .en(rise),
         .din(enc[ch]),
         .tap_hi(tap_hi[ch]),
         .tap_lo(tap_lo[ch])
      );
   end

   // sync capture, chaining and ready reset counter
   rdr_state_t rdr_st_ff, nxt_rdr_st;
   logic [CNT_W-1:0] rdr_cnt_ff, nxt_rdr_cnt;
   logic sync_cap_ff, nxt_sync_cap;
   logic chain_ff, nxt_chain;
   logic sync_start, fire;

   always_comb begin
      nxt_sync_cap = cap_en ? sync_s2_ff : sync_cap_ff; // R07
      sync_start = cap_en && sync_s2_ff && !sync_cap_ff; // R10
      nxt_chain = rise ? sync_cap_ff : chain_ff; // R13
      nxt_rdr_st = rdr_st_ff;
      nxt_rdr_cnt = rdr_cnt_ff;
      fire = 1'b0;
      case (rdr_st_ff)
         RDR_IDLE: begin
            nxt_rdr_cnt = '0;
         end
         RDR_COUNT: begin
            if (rise) begin
               nxt_rdr_cnt = rdr_cnt_ff - 1'b1;
               if (rdr_cnt_ff == CNT_W'(1)) begin
                  fire = 1'b1; // R08
                  nxt_rdr_st = RDR_IDLE;
               end
            end
         end
         default: begin
            nxt_rdr_st = RDR_IDLE;
            nxt_rdr_cnt = '0;
         end
      endcase
      if (sync_start) begin
         nxt_rdr_st = RDR_COUNT;
         // R06 R12
         nxt_rdr_cnt = two_word_mode ? CNT_W'(RDR_DUAL) : CNT_W'(RDR_SINGLE);
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdr_st_ff <= RDR_IDLE;
         rdr_cnt_ff <= '0;
         sync_cap_ff <= 1'b0;
         chain_ff <= 1'b0;
      end else begin
         rdr_st_ff <= nxt_rdr_st;
         rdr_cnt_ff <= nxt_rdr_cnt;
         sync_cap_ff <= nxt_sync_cap;
         chain_ff <= nxt_chain;
      end
   end

   // per-channel output update and data ready
   port_out_t core_out_ff [NCH];
   port_out_t nxt_core_out [NCH];
   logic [NCH-1:0] core_rdy_ff, nxt_core_rdy, pair_ff, nxt_pair, upd;
   port_out_t lag_out_ff, nxt_lag_out;
   logic lag_rdy_ff, nxt_lag_rdy;
   port_out_t [NCH-1:0] port_ff, nxt_port;
   logic [NCH-1:0] rdy_ff, nxt_rdy;

   always_comb begin
      for (int ch = 0; ch < NCH; ch++) begin
         nxt_core_out[ch] = core_out_ff[ch];
         nxt_core_rdy[ch] = core_rdy_ff[ch];
         nxt_pair[ch] = pair_ff[ch];
         upd[ch] = rise && (!two_word_mode || pair_ff[ch]); // R15
         if (rise) begin
            nxt_pair[ch] = two_word_mode ? !pair_ff[ch] : 1'b0;
         end
         if (upd[ch]) begin
            nxt_core_out[ch].hi = tap_hi[ch];
            nxt_core_out[ch].lo = two_word_mode ? tap_lo[ch] : CODE_IDLE; // R14
            nxt_core_rdy[ch] = !core_rdy_ff[ch]; // R15
         end
         if (fire) begin
            nxt_core_rdy[ch] = 1'b0; // R08
            nxt_pair[ch] = 1'b0;
         end
      end
      nxt_lag_out = rise ? core_out_ff[1] : lag_out_ff; // R05
      nxt_lag_rdy = rise ? core_rdy_ff[1] : lag_rdy_ff; // R05
      nxt_port[0] = core_out_ff[0];
      nxt_rdy[0] = core_rdy_ff[0];
      nxt_port[1] = interleave ? lag_out_ff : core_out_ff[1]; // R05
      nxt_rdy[1] = interleave ? lag_rdy_ff : core_rdy_ff[1];
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int ch = 0; ch < NCH; ch++) begin
            core_out_ff[ch] <= '{hi: CODE_IDLE, lo: CODE_IDLE};
         end
         core_rdy_ff <= '0;
         pair_ff <= '0;
         lag_out_ff <= '{hi: CODE_IDLE, lo: CODE_IDLE};
         lag_rdy_ff <= 1'b0;
         port_ff <= '0;
         rdy_ff <= '0;
      end else begin
         for (int ch = 0; ch < NCH; ch++) begin
            core_out_ff[ch] <= nxt_core_out[ch];
         end
         core_rdy_ff <= nxt_core_rdy;
         pair_ff <= nxt_pair;
         lag_out_ff <= nxt_lag_out;
         lag_rdy_ff <= nxt_lag_rdy;
         port_ff <= nxt_port;
         rdy_ff <= nxt_rdy;
      end
   end

   assign channel_port = port_ff;
   assign channel_data_ready = rdy_ff;
   assign chained_sync_output = chain_ff;

   // checks
   over_saturate_a: assert property ( // R02
      (fifo_vld && fifo_dat.a > RAW_MAX) |->
      (enc[0].word == 12'hFFF && !enc[0].in_range))
      else $error("over-range word not saturated");
   under_saturate_a: assert property ( // R03
      (fifo_vld && fifo_dat.b < RAW_MIN) |->
      (enc[1].word == 12'h000 && !enc[1].in_range))
      else $error("under-range word not saturated");
   mid_code_a: assert property ( // R04
      (fifo_vld && fifo_dat.a == 14'sh0000) |->
      (enc[0].word == 12'h800 && enc[0].in_range))
      else $error("midscale code wrong");
   range_flag_a: assert property ( // R01
      (fifo_vld && fifo_dat.b <= RAW_MAX && fifo_dat.b >= RAW_MIN) |->
      enc[1].in_range)
      else $error("in-range flag missing");
   ready_reset_a: assert property ( // R08
      fire |=> (core_rdy_ff == '0) ##1
      (!rdy_ff[0] && (interleave || !rdy_ff[1])))
      else $error("data ready not reset after sync");
   rdr_count_a: assert property ( // R12
      (sync_start && !two_word_mode) |=>
      (rdr_cnt_ff == CNT_W'(RDR_SINGLE) && rdr_st_ff == RDR_COUNT))
      else $error("ready reset delay not loaded");
   chain_delay_a: assert property ( // R13
      rise |=> (chain_ff == $past(sync_cap_ff)))
      else $error("chained sync not one cycle");
   low_port_off_a: assert property ( // R14
      (upd[0] && !two_word_mode) |=> (core_out_ff[0].lo == CODE_IDLE))
      else $error("low port active in single-word mode");
   lag_channel_a: assert property ( // R05
      (rise && interleave) |=> (lag_rdy_ff == $past(core_rdy_ff[1])))
      else $error("interleaved lag wrong");
   pair_rate_a: assert property ( // R15
      (two_word_mode && rise && !pair_ff[0] && !fire) |=>
      $stable(core_rdy_ff[0]))
      else $error("ready toggled mid pair");
   edge_capture_a: assert property ( // R07
      (!cap_en) |=> $stable(sync_cap_ff))
      else $error("sync captured off selected edge");
   dual_count_a: assert property ( // R12
      (sync_start && two_word_mode) |=>
      (rdr_cnt_ff == CNT_W'(RDR_DUAL) && rdr_st_ff == RDR_COUNT))
      else $error("two-word ready reset delay not loaded");
   over_second_a: assert property ( // R02
      (fifo_vld && fifo_dat.b > RAW_MAX) |->
      (enc[1].word == WORD_ONES && !enc[1].in_range))
      else $error("over-range word b not saturated");
   under_first_a: assert property ( // R03
      (fifo_vld && fifo_dat.a < RAW_MIN) |->
      (enc[0].word == WORD_ZERO && !enc[0].in_range))
      else $error("under-range word a not saturated");
   step_below_a: assert property ( // R04
      (fifo_vld && fifo_dat.a == -14'sh0001) |->
      (enc[0].word == 12'h7FF && enc[0].in_range))
      else $error("code below midscale wrong");
   hi_update_a: assert property ( // R11
      upd[0] |=> (core_out_ff[0].hi == $past(tap_hi[0])))
      else $error("high port not from high tap");
   lo_update_a: assert property ( // R15
      (upd[1] && two_word_mode) |=>
      (core_out_ff[1].lo == $past(tap_lo[1])))
      else $error("low port not from low tap");
   single_toggle_a: assert property ( // R15
      (rise && !two_word_mode && !fire) |=>
      (core_rdy_ff[0] != $past(core_rdy_ff[0])))
      else $error("ready not toggled in single-word mode");
   straight_b_a: assert property ( // R05
      !interleave |=> (rdy_ff[1] == $past(core_rdy_ff[1])))
      else $error("channel b lags without interleave");
   lag_data_a: assert property ( // R05
      (rise && interleave) |=> (lag_out_ff == $past(core_out_ff[1])))
      else $error("interleaved data lag wrong");
   count_bound_a: assert property ( // R12
      (rdr_st_ff == RDR_COUNT) |->
      (rdr_cnt_ff != '0 && rdr_cnt_ff <= CNT_W'(RDR_DUAL)))
      else $error("ready reset counter out of range");
   chain_hold_a: assert property ( // R13
      !rise |=> $stable(chain_ff))
      else $error("chained sync moved off sampling edge");
   ready_hold_a: assert property ( // R15
      !rise |=> $stable(core_rdy_ff))
      else $error("ready moved off sampling edge");
   low_idle_a: assert property ( // R14
      !two_word_mode |=> (port_ff[0].lo == CODE_IDLE))
      else $error("low port driven in single-word mode");
endmodule : adc_out_core
`default_nettype wire

// File: logic/adc_out_pkg.sv
// Purpose: shared constants and types of the converter output logic
// Assumes: raw samples arrive as 14-bit two's complement values
// Notes: all latencies counted in sampling-clock cycles
// What this block does
// R01 - twelve-bit word plus in-range flag
// R02 - over top: all ones, flag cleared
// R03 - under bottom: all zeros, flag cleared
// R04 - offset binary, zero gives top bit only
// R05 - interleaved channel b lags one cycle
// R06 - sync behaves same in both modes
// R07 - edge select picks rising or falling sync
// R08 - sync drives data ready to zero
// R09 - latency in whole sampling-clock cycles
// R10 - partner holds sync long enough
// R11 - latency 22 high port, 20 low
// R12 - ready reset after 26 or 27
// R13 - sync chained out one cycle later
// R14 - single-word mode disables low port
// R15 - two-word mode halves ready toggle rate
package adc_out_pkg;
   localparam int WORD_W = 12;
   localparam int RAW_W = 14;
   localparam int NCH = 2;
   localparam int PIPE_HI_LAT = 22;
   localparam int PIPE_LO_LAT = 20;
   localparam int RDR_SINGLE = 26;
   localparam int RDR_DUAL = 27;
   localparam int SYNC_MIN_WIDTH = 16;
   localparam int FIFO_DEPTH = 32;
   localparam int CNT_W = 5;
   localparam logic signed [RAW_W-1:0] RAW_MAX = 14'sh07FF;
   localparam logic signed [RAW_W-1:0] RAW_MIN = -14'sh0800;
   localparam logic [WORD_W-1:0] WORD_ONES = 12'hFFF;
   localparam logic [WORD_W-1:0] WORD_ZERO = 12'h000;
   localparam logic [WORD_W-1:0] MID_FLIP = 12'h800;

   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic in_range;
   } coded_t;

   typedef struct packed {
      logic signed [RAW_W-1:0] b;
      logic signed [RAW_W-1:0] a;
   } raw_pair_t;

   typedef struct packed {
      coded_t hi;
      coded_t lo;
   } port_out_t;

   typedef enum logic [1:0] {
      RDR_IDLE = 2'b01,
      RDR_COUNT = 2'b10
   } rdr_state_t;

   localparam coded_t CODE_IDLE = '{word: 12'h000, in_range: 1'b0};

   // saturating offset-binary coder
   function automatic coded_t encode(input logic signed [RAW_W-1:0] raw);
      coded_t c;
      c.word = WORD_ZERO;
      c.in_range = 1'b0;
      if (raw > RAW_MAX) begin
         c.word = WORD_ONES; // R02
         c.in_range = 1'b0;
      end else if (raw < RAW_MIN) begin
         c.word = WORD_ZERO; // R03
         c.in_range = 1'b0;
      end else begin
         c.word = raw[WORD_W-1:0] ^ MID_FLIP; // R04
         c.in_range = 1'b1; // R01
      end
      return c;
   endfunction : encode
endpackage : adc_out_pkg

// File: logic/sample_fifo.sv
// Purpose: sample buffer with registered read data
// Assumes: one clock domain
// Notes: in_ready low when full, out_valid low when empty
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic vld_ff, nxt_vld;
   logic room_ff, nxt_room;
   logic [WIDTH-1:0] dat_ff, nxt_dat;
   logic push, load;

   always_comb begin
      push = in_valid && room_ff;
      load = (cnt_ff != '0) && (!vld_ff || out_ready);
      nxt_wptr = push ? wptr_ff + 1'b1 : wptr_ff;
      nxt_rptr = load ? rptr_ff + 1'b1 : rptr_ff;
      nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(load);
      nxt_vld = load ? 1'b1 : (out_ready ? 1'b0 : vld_ff);
      nxt_dat = load ? mem[rptr_ff] : dat_ff;
      // the output register counts towards the depth
      nxt_room = (nxt_cnt + (AW+1)'(nxt_vld)) != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
         cnt_ff <= '0;
         vld_ff <= 1'b0;
         room_ff <= 1'b1;
         dat_ff <= '0;
      end else begin
         wptr_ff <= nxt_wptr;
         rptr_ff <= nxt_rptr;
         cnt_ff <= nxt_cnt;
         vld_ff <= nxt_vld;
         room_ff <= nxt_room;
         dat_ff <= nxt_dat;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wptr_ff] <= in_data;
      end
   end

   assign in_ready = room_ff;
   assign out_valid = vld_ff;
   assign out_data = dat_ff;
endmodule : sample_fifo
`default_nettype wire

// File: logic/pipe_delay.sv
// Purpose: per-channel sampling pipeline with two output taps
// Assumes: en pulses once per sampling-clock rising edge
// Notes: tap k holds the word entered k edges ago
`timescale 1ns/1ps
`default_nettype none
module pipe_delay
   import adc_out_pkg::*;
#(
   parameter int DEPTH = PIPE_HI_LAT,
   parameter int HI_TAP = PIPE_HI_LAT,
   parameter int LO_TAP = PIPE_LO_LAT
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // shift control
   input wire logic en,
   input wire coded_t din,
   // taps
   output coded_t tap_hi,
   output coded_t tap_lo
);
   coded_t stage_ff [DEPTH];
   coded_t nxt_stage [DEPTH];

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         nxt_stage[i] = stage_ff[i];
      end
      if (en) begin
         nxt_stage[0] = din;
         for (int i = 1; i < DEPTH; i++) begin
            nxt_stage[i] = stage_ff[i-1]; // R09
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < DEPTH; i++) begin
            stage_ff[i] <= CODE_IDLE;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            stage_ff[i] <= nxt_stage[i];
         end
      end
   end

   assign tap_hi = stage_ff[HI_TAP-1]; // R11
   assign tap_lo = stage_ff[LO_TAP-1]; // R11
endmodule : pipe_delay
`default_nettype wire

// File: bench/rx_capture.sv
// Purpose: receiving logic capturing channel a words on each channel a data ready edge
// Assumes: data ready changes once per output word
// Notes: counts channel a edges for rate checks
`timescale 1ns/1ps
`default_nettype none
module rx_capture
   import adc_out_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // converter outputs
   input wire logic [NCH-1:0] channel_data_ready,
   input wire port_out_t [NCH-1:0] channel_port,
   // captured view
   output logic [15:0] edges_a,
   output port_out_t word_a
);
   logic prev_ff;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         prev_ff <= 1'b0;
         edges_a <= 16'h0000;
         word_a <= '0;
      end else begin
         prev_ff <= channel_data_ready[0];
         if (channel_data_ready[0] != prev_ff) begin
            edges_a <= edges_a + 16'h0001;
            word_a <= channel_port[0];
         end
      end
   end
endmodule : rx_capture
`default_nettype wire

// File: bench/test_adc_out_core.sv
// Purpose: self-checking bench of the converter output logic
// Assumes: 10 MHz clk_sys, 800 ns sampling clock
// Notes: each scenario resets the block with its own straps
`timescale 1ns/1ps
`default_nettype none
module test_adc_out_core
   import adc_out_pkg::*;
;
   logic clk_sys, nrst, samp_clk, samp_run, sync_trig, chain;
   logic sel, two, il, s_valid, s_ready;
   raw_pair_t sample;
   port_out_t [NCH-1:0] port;
   port_out_t word_a;
   logic [NCH-1:0] rdy;
   logic [15:0] edges_a;
   int err_total, checks_done, samp_cnt, cycles;
   logic [13:0] raw_tab [7] = '{14'h07FF, 14'h0800, 14'h0000, 14'h3FFF,
      14'h3800, 14'h37FF, 14'h0001};
   logic [12:0] exp_tab [7] = '{13'h1FFF, 13'h1FFE, 13'h1001, 13'h0FFF,
      13'h0001, 13'h0000, 13'h1003};

   adc_out_core u_dut (.clk_sys(clk_sys), .nrst(nrst), .samp_clk(samp_clk),
      .sync_trigger_input(sync_trig), .chained_sync_output(chain),
      .sync_edge_select(sel), .two_word_mode(two), .interleave(il),
      .sample_valid(s_valid), .sample(sample), .sample_ready(s_ready),
      .channel_port(port), .channel_data_ready(rdy));

   rx_capture u_rx (.clk_sys(clk_sys), .nrst(nrst),
      .channel_data_ready(rdy), .channel_port(port), .edges_a(edges_a),
      .word_a(word_a));

   initial begin
      clk_sys = 0;
      forever #50 clk_sys = ~clk_sys;
   end

   // sampling clock, phase unrelated, parks low when stopped
   initial begin
      samp_clk = 0;
      #137;
      forever begin
         #400;
         if (samp_run || samp_clk) samp_clk = ~samp_clk;
         if (samp_clk) samp_cnt++;
      end
   end

   task automatic fail(input string msg);
      err_total++;
      $display("Error %0t: %s", $time, msg);
   endtask : fail

   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fail("timeout");
         end_of_test();
      end
   end

   task automatic do_reset(input logic e, input logic t, input logic i);
      @(posedge clk_sys) #1;
      nrst = 0;
      sel = e;
      two = t;
      il = i;
      repeat (8) @(posedge clk_sys);
      #1 nrst = 1;
   endtask : do_reset

   // wait for sampling rise t, then let the output register settle
   task automatic wait_to(input int t);
      while (samp_cnt < t) @(posedge samp_clk);
      repeat (5) @(posedge clk_sys);
      #1;
   endtask : wait_to

   task automatic test_coding(input logic i);
      int r0;
      logic [12:0] prev_b;
      do_reset(0, 0, i);
      wait_to(samp_cnt + 30);
      @(posedge samp_clk);
      #1 r0 = samp_cnt;
      for (int k = 0; k < 7; k++) begin
         @(posedge clk_sys) #1;
         s_valid = 1;
         sample.a = raw_tab[k];
         sample.b = raw_tab[(k+3)%7];
      end
      @(posedge clk_sys) #1;
      s_valid = 0;
      prev_b = 13'h1001;
      wait_to(r0 + 22);
      if (port[0].hi !== 13'h1001) fail("word early");
      else checks_done++;
      for (int k = 0; k < 7; k++) begin
         wait_to(r0 + 23 + k);
         if (port[0].hi !== exp_tab[k]) fail("word a");
         else checks_done++;
         if (port[1].hi !== (i ? prev_b : exp_tab[(k+3)%7]))
            fail("word b");
         else checks_done++;
         if (rdy[1] !== (rdy[0] ^ i)) fail("ready b");
         else checks_done++;
         prev_b = exp_tab[(k+3)%7];
      end
   endtask : test_coding

   task automatic test_rate(input logic t);
      int e0;
      do_reset(0, t, 0);
      wait_to(samp_cnt + 30);
      e0 = edges_a;
      wait_to(samp_cnt + 8);
      if (edges_a - e0 !== (t ? 4 : 8)) fail("ready rate");
      else checks_done++;
      if (t) begin
         if (port[0].lo !== 13'h1001 || port[1].lo !== 13'h1001)
            fail("low word");
         else checks_done++;
      end else begin
         if (word_a.lo !== CODE_IDLE || port[1].lo !== CODE_IDLE)
            fail("low port on");
         else checks_done++;
      end
   endtask : test_rate

   task automatic test_fill;
      int n;
      int s0;
      do_reset(0, 0, 0);
      samp_run = 0;
      repeat (12) @(posedge clk_sys);
      #1 n = 0;
      s_valid = 1;
      sample.a = 14'h0123;
      sample.b = 14'h0000;
      repeat (40) begin
         @(negedge clk_sys);
         if (s_ready) n++;
         @(posedge clk_sys) #1;
      end
      if (n !== FIFO_DEPTH || s_ready !== 1'b0) fail("fill");
      else checks_done++;
      s_valid = 0;
      s0 = samp_cnt;
      samp_run = 1;
      wait_to(s0 + 1);
      if (s_ready !== 1'b1) fail("no drain"); else checks_done++;
      wait_to(s0 + 30);
      if (port[0].hi !== 13'h1247) fail("buffered word");
      else checks_done++;
      wait_to(s0 + 60);
      if (port[0].hi !== 13'h1001) fail("empty fill");
      else checks_done++;
   endtask : test_fill

   task automatic test_sync(input logic e, input logic t);
      int r;
      int z;
      do_reset(e, t, 0);
      wait_to(samp_cnt + 2);
      // raise away from the selected capture edge
      if (e) @(posedge samp_clk); else @(negedge samp_clk);
      @(posedge clk_sys) #1;
      sync_trig = 1;
      @(posedge samp_clk);
      #1 r = samp_cnt;
      z = r + (t ? RDR_DUAL : RDR_SINGLE) - int'(e);
      wait_to(r);
      if (chain !== e) fail("sync edge"); else checks_done++;
      wait_to(r + 1);
      if (chain !== 1'b1) fail("chained sync"); else checks_done++;
      wait_to(z);
      if (rdy !== 2'b00) fail("ready reset");
      else checks_done++;
      sync_trig = 0;
      if (!t) begin
         wait_to(z + 1);
         if (rdy !== 2'b11) fail("ready restart"); else checks_done++;
      end
   endtask : test_sync

   initial begin
      nrst = 0;
      samp_run = 1;
      sync_trig = 0;
      sel = 0;
      two = 0;
      il = 0;
      s_valid = 0;
      sample = '0;
      test_coding(0);
      test_coding(1);
      test_rate(0);
      test_rate(1);
      test_fill();
      for (int k = 0; k < 4; k++) test_sync(k[0], k[1]);
      end_of_test();
   end
endmodule : test_adc_out_core
`default_nettype wire
